/* rtl/fwce_pkg.sv */
// Package: constants, types and register map for the firmware update engine.
// Assumes a single 125 MHz clock domain and an APB register bus.
// Notes on behaviour
// - Update capability is optional and advertised in a readable bit.
// - Two host-updatable banks A and B, plus an optional factory image.
// - Exactly one bank committed; only the commit command or a reset (back to bank A) changes it.
// - One running image; changed by run command, reset, or an idle fallback to the factory image when both banks are invalid.
// - After reset the committed bank runs.
// - Factory image may be reported as running, neither A nor B.
// - Invalid to valid only after a correct start-write-complete sequence or a reset; the copy command also validates the other bank.
// - Header length reported in header_length_field for the features command.
// - Target bank marked invalid before alteration until successful completion.
// - After successful start, write block commands are accepted.
// - Complete validates, ends session, reports failure in status byte.
// - Firmware info query answered even without update support.
// - Status byte updated before completion flag is set.
package fwce_pkg;

    // Command codes
    localparam logic [15:0] CMD_FEATURES = 16'h0041;
    localparam logic [15:0] CMD_INFO     = 16'h0100;
    localparam logic [15:0] CMD_START    = 16'h0101;
    localparam logic [15:0] CMD_ABORT    = 16'h0102;
    localparam logic [15:0] CMD_WR_LOCAL = 16'h0103;
    localparam logic [15:0] CMD_WR_EXT   = 16'h0104;
    localparam logic [15:0] CMD_COMPLETE = 16'h0107;
    localparam logic [15:0] CMD_COPY     = 16'h0108;
    localparam logic [15:0] CMD_RUN      = 16'h0109;
    localparam logic [15:0] CMD_COMMIT   = 16'h010A;

    // APB byte addresses
    localparam logic [11:0] ADDR_CMD       = 12'h000;
    localparam logic [11:0] ADDR_ARG       = 12'h004;
    localparam logic [11:0] ADDR_STATUS    = 12'h008;
    localparam logic [11:0] ADDR_FWSTAT    = 12'h00C;
    localparam logic [11:0] ADDR_CAPS      = 12'h010;
    localparam logic [11:0] ADDR_HDR_LEN   = 12'h08A << 2;
    localparam logic [11:0] ADDR_BLK_ADDR  = 12'h014;
    localparam logic [7:0]  HDR_LEN_INDEX  = 8'h8A;

    // Status byte codes
    localparam logic [7:0] ST_IDLE      = 8'h00;
    localparam logic [7:0] ST_BUSY      = 8'h80;
    localparam logic [7:0] ST_SUCCESS   = 8'h01;
    localparam logic [7:0] ST_BAD_CMD   = 8'h41;
    localparam logic [7:0] ST_NO_SESS   = 8'h42;
    localparam logic [7:0] ST_BAD_PARAM = 8'h43;
    localparam logic [7:0] ST_VAL_FAIL  = 8'h45;

    // Reset and capability values
    localparam logic [7:0] HDR_LEN_RESET   = 8'h40;
    localparam logic [1:0] BANK_A          = 2'd0;
    localparam logic [1:0] BANK_B          = 2'd1;
    localparam logic [1:0] BANK_FACTORY    = 2'd2;
    localparam int         CAPS_UPD_BIT    = 0;
    localparam int         CAPS_FACT_BIT   = 1;
    localparam int         CAPS_ABORT_BIT  = 2;
    localparam int         ARG_BANK_BIT    = 0;
    localparam int         ARG_VALID_BIT   = 1;
    localparam int         EXEC_CYCLES     = 4;

    // Engine states, Gray coded along idle-decode-exec-status-flag
    typedef enum logic [2:0] {
        FWCE_IDLE   = 3'b000,
        FWCE_DECODE = 3'b001,
        FWCE_EXEC   = 3'b011,
        FWCE_STATUS = 3'b010,
        FWCE_FLAG   = 3'b110
    } fwce_state_t;

    // Command carried from register file to engine
    typedef struct packed {
        logic [15:0] code;
        logic [15:0] arg;
    } fwce_cmd_t;

    // Per-bank status
    typedef struct packed {
        logic invalid;
        logic committed;
        logic running;
    } fwce_bank_t;

endpackage : fwce_pkg

/* rtl/fwce_apb.sv */
// APB slave decoding the engine's registers.
// Assumes APB3 masters; always answers in the access cycle.
`timescale 1ns/1ps
module fwce_apb
    import fwce_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Register views
    input  wire logic [31:0] rd_word,
    input  wire logic        rd_hit,
    output logic             wr_stb,
    output logic             rd_stb
);

    ////////////////////////////////////////////////////////////////////////
    // Zero-wait handshake; unmapped address flags an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~rd_hit;
    assign wr_stb  = psel & penable & pwrite & rd_hit;
    assign rd_stb  = psel & penable & ~pwrite;

    // Read data from a flop, captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rd_hit ? rd_word : 32'h0000_0000;
        end
    end

endmodule : fwce_apb

/* rtl/fwce_engine.sv */
// Top of the firmware update command engine: registers, banks, sequencer.
// Assumes a host that writes a command word and polls status and flag.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module fwce_engine
    import fwce_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device straps and image checks
    input  wire logic        update_supported,
    input  wire logic        factory_present,
    input  wire logic        image_check_ok,
    // Observed state
    output logic [1:0]       running_bank,
    output logic             command_done
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    fwce_state_t state_q;
    fwce_cmd_t   cmd_q;
    fwce_bank_t  bank_q [2];
    logic [7:0]  status_q;
    logic        flag_q;
    logic        session_q;
    logic        sess_bank_q;
    logic [15:0] blk_cnt_q;
    logic [2:0]  exec_cnt_q;
    logic [7:0]  result_q;
    logic        upd_q;
    logic        fact_q;
    logic        on_factory_q;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        wr_stb;
    logic        cmd_wr;
    logic        flag_clr;

    // Nibble of one bank for the firmware status word
    function automatic logic [3:0] nib(input fwce_bank_t b);
        nib = {1'b0, b.invalid, b.committed, b.running};
    endfunction : nib

    // Update-type command needs the optional capability
    function automatic logic is_upd(input logic [15:0] c);
        is_upd = (c >= CMD_START) && (c <= CMD_COMMIT);
    endfunction : is_upd

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    fwce_apb u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rd_word (rd_word),
        .rd_hit  (rd_hit),
        .wr_stb  (wr_stb),
        .rd_stb  ()
    );

    // Read mux; flag bit sits at bit 8 of status
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            ADDR_CMD:      rd_word = {cmd_q.arg, cmd_q.code};
            ADDR_ARG:      rd_word = {16'h0000, cmd_q.arg};
            ADDR_STATUS:   rd_word = {23'h000000, flag_q, status_q};
            ADDR_FWSTAT:   rd_word = {24'h000000, nib(bank_q[1]),
                                      nib(bank_q[0])};
            ADDR_CAPS:     rd_word = {29'h00000000, upd_q, fact_q,
                                      upd_q};
            ADDR_HDR_LEN:  rd_word = {24'h000000, HDR_LEN_RESET};
            ADDR_BLK_ADDR: rd_word = {16'h0000, blk_cnt_q};
            default:       rd_hit  = 1'b0;
        endcase
    end

    // Writing the command word launches a command when idle
    assign cmd_wr   = wr_stb && (paddr == ADDR_CMD) && (state_q == FWCE_IDLE);
    // Writing 1 to bit 8 of status clears the completion flag
    assign flag_clr = wr_stb && (paddr == ADDR_STATUS) && pwdata[8];

    ////////////////////////////////////////////////////////////////////////
    // Capability straps, resampled on every clock once reset is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upd_q  <= 1'b0;
            fact_q <= 1'b0;
        end else begin
            upd_q  <= update_supported;
            fact_q <= factory_present;
        end
    end

    // Command capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= '0;
        end else if (cmd_wr) begin
            // Code sits in the low half of the word, argument above it
            cmd_q.code <= pwdata[15:0];
            cmd_q.arg  <= pwdata[31:16];
        end else if (wr_stb && paddr == ADDR_ARG && state_q == FWCE_IDLE) begin
            cmd_q.arg <= pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: decode, execute for a fixed time, status, then flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= FWCE_IDLE;
            exec_cnt_q <= 3'd0;
        end else begin
            case (state_q)
                FWCE_IDLE: begin
                    if (cmd_wr) begin
                        state_q <= FWCE_DECODE;
                    end
                end
                FWCE_DECODE: begin
                    state_q    <= FWCE_EXEC;
                    exec_cnt_q <= 3'(EXEC_CYCLES - 1);
                end
                FWCE_EXEC: begin
                    if (exec_cnt_q == 3'd0) begin
                        state_q <= FWCE_STATUS;
                    end else begin
                        exec_cnt_q <= exec_cnt_q - 3'd1;
                    end
                end
                FWCE_STATUS: state_q <= FWCE_FLAG;
                FWCE_FLAG:   state_q <= FWCE_IDLE;
                default:     state_q <= FWCE_IDLE;
            endcase
        end
    end

    // Result decided in decode, applied to banks at end of execution
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= ST_IDLE;
        end else if (state_q == FWCE_DECODE) begin
            if (is_upd(cmd_q.code) && !upd_q) begin
                result_q <= ST_BAD_CMD;
            end else begin
                case (cmd_q.code)
                    CMD_FEATURES, CMD_INFO: result_q <= ST_SUCCESS;
                    CMD_START: result_q <= ST_SUCCESS;
                    CMD_ABORT: result_q <= ST_SUCCESS;
                    CMD_WR_LOCAL, CMD_WR_EXT: begin
                        result_q <= session_q ? ST_SUCCESS
                                              : ST_NO_SESS;
                    end
                    CMD_COMPLETE: begin
                        if (!session_q) begin
                            result_q <= ST_NO_SESS;
                        end else begin
                            result_q <= image_check_ok ? ST_SUCCESS
                                                       : ST_VAL_FAIL;
                        end
                    end
                    CMD_COPY, CMD_RUN, CMD_COMMIT: begin
                        result_q <= (!session_q &&
                                     !bank_q[cmd_q.arg[ARG_BANK_BIT]].invalid)
                                    ? ST_SUCCESS : ST_BAD_PARAM;
                    end
                    default: result_q <= ST_BAD_CMD;
                endcase
            end
        end
    end

    // Status byte: busy while working, result before the flag rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= ST_IDLE;
        end else if (cmd_wr) begin
            status_q <= ST_BUSY;
        end else if (state_q == FWCE_STATUS) begin
            status_q <= result_q;
        end
    end

    // Completion flag, set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (state_q == FWCE_FLAG) begin
            flag_q <= 1'b1;
        end else if (flag_clr || cmd_wr) begin
            flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Download session and block counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            session_q   <= 1'b0;
            sess_bank_q <= 1'b0;
            blk_cnt_q   <= 16'h0000;
        end else if (state_q == FWCE_STATUS && result_q == ST_SUCCESS) begin
            case (cmd_q.code)
                CMD_START: begin
                    session_q   <= 1'b1;
                    sess_bank_q <= ~bank_q[1].running;
                    blk_cnt_q   <= 16'h0000;
                end
                CMD_WR_LOCAL, CMD_WR_EXT: blk_cnt_q <= blk_cnt_q + 16'h0001;
                default: session_q <= session_q;
            endcase
        end else if (state_q == FWCE_STATUS &&
                     (cmd_q.code == CMD_COMPLETE ||
                      cmd_q.code == CMD_ABORT) && upd_q) begin
            session_q <= 1'b0;
        end
        if (state_q == FWCE_STATUS && result_q == ST_SUCCESS &&
            (cmd_q.code == CMD_COMPLETE || cmd_q.code == CMD_ABORT)) begin
            session_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bank administration: commit, run, validity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_q[0]    <= '{invalid: 1'b0, committed: 1'b1,
                              running: 1'b1};
            bank_q[1]    <= '{invalid: 1'b0, committed: 1'b0,
                              running: 1'b0};
            on_factory_q <= 1'b0;
        end else if (state_q == FWCE_STATUS) begin
            case (cmd_q.code)
                CMD_START: begin
                    if (result_q == ST_SUCCESS) begin
                        // Idle bank becomes the target; mark it first
                        bank_q[~bank_q[1].running].invalid <= 1'b1;
                    end
                end
                CMD_ABORT: begin
                    if (session_q) begin
                        bank_q[sess_bank_q].invalid <= 1'b1;
                    end
                end
                CMD_COMPLETE: begin
                    if (session_q) begin
                        bank_q[sess_bank_q].invalid <=
                            (result_q != ST_SUCCESS);
                    end
                end
                CMD_COPY: begin
                    if (result_q == ST_SUCCESS) begin
                        bank_q[~cmd_q.arg[ARG_BANK_BIT]].invalid <= 1'b0;
                    end
                end
                CMD_RUN: begin
                    if (result_q == ST_SUCCESS) begin
                        bank_q[0].running <= ~cmd_q.arg[ARG_BANK_BIT];
                        bank_q[1].running <=  cmd_q.arg[ARG_BANK_BIT];
                        on_factory_q      <= 1'b0;
                    end
                end
                CMD_COMMIT: begin
                    if (result_q == ST_SUCCESS) begin
                        bank_q[0].committed <= ~cmd_q.arg[ARG_BANK_BIT];
                        bank_q[1].committed <=  cmd_q.arg[ARG_BANK_BIT];
                    end
                end
                default: on_factory_q <= on_factory_q;
            endcase
        end else if (state_q == FWCE_IDLE && fact_q &&
                     bank_q[0].invalid && bank_q[1].invalid &&
                     !session_q) begin
            // No runnable bank: fall back to the factory image
            bank_q[0].running <= 1'b0;
            bank_q[1].running <= 1'b0;
            on_factory_q      <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Observed outputs
    assign running_bank = on_factory_q ? BANK_FACTORY :
                          (bank_q[1].running ? BANK_B : BANK_A);
    assign command_done = flag_q;

endmodule : fwce_engine

/* tb/fwce_engine_asserts.sv */
// Checker: timing and value relations at the engine's ports.
// Assumes it is bound to fwce_engine; one clock domain.
`timescale 1ns/1ps
module fwce_engine_asserts
    import fwce_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Straps and observed state
    input wire logic        update_supported,
    input wire logic        factory_present,
    input wire logic        image_check_ok,
    input wire logic [1:0]  running_bank,
    input wire logic        command_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       cmd_wr;
    logic       rd_acc;
    logic [3:0] since_q;
    assign cmd_wr = psel && penable && pwrite && paddr == ADDR_CMD;
    assign rd_acc = psel && penable && !pwrite;
    // Cycles since last command write; saturates so idle time is harmless
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_q <= 4'hF;
        else if (cmd_wr) since_q <= 4'h0;
        else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_run_legal; running_bank != 2'h3; endproperty
    a_run_legal: assert property (p_run_legal)
        else $error("running bank code out of range");
    property p_reset_run; $rose(presetn) |-> running_bank == BANK_A;
    endproperty
    a_reset_run: assert property (p_reset_run)
        else $error("committed bank not running after reset");
    property p_done_window;
        $rose(command_done) |-> since_q inside {[4'h2:4'hE]};
    endproperty
    a_done_window: assert property (p_done_window)
        else $error("completion flag without recent command");
    property p_done_clear;
        cmd_wr && command_done |-> ##[1:2] !command_done;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("completion flag not cleared by new command");
    property p_hdr_len;
        rd_acc && paddr == ADDR_HDR_LEN |-> prdata[7:0] == HDR_LEN_RESET;
    endproperty
    a_hdr_len: assert property (p_hdr_len)
        else $error("header length read wrong");
    property p_caps;
        rd_acc && paddr == ADDR_CAPS
            |-> prdata[CAPS_UPD_BIT] == $past(update_supported, 2);
    endproperty
    a_caps: assert property (p_caps)
        else $error("update capability bit wrong");
    property p_one_commit;
        rd_acc && paddr == ADDR_FWSTAT
            |-> prdata[1] != prdata[5] && !prdata[3] && !prdata[7];
    endproperty
    a_one_commit: assert property (p_one_commit)
        else $error("not exactly one committed bank");
    property p_run_cause; $changed(running_bank) |-> since_q <= 4'hE;
    endproperty
    a_run_cause: assert property (p_run_cause)
        else $error("running bank changed without command");
    // Main scenarios reached
    c_done: cover property ($rose(command_done));
    c_run_b: cover property (running_bank == BANK_B);
    c_hdr: cover property (rd_acc && paddr == ADDR_HDR_LEN);
endmodule : fwce_engine_asserts

/* tb/fwce_host_model.sv */
// Host model: APB master that issues firmware commands and polls status.
// Assumes a slave answering with pready; the testbench calls its tasks.
`timescale 1ns/1ps
module fwce_host_model
    import fwce_pkg::*;
(
    // Clock
    input  wire logic        pclk,
    // APB
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Bus idle from time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
    end
    // One transfer; caller enters just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // Idle edge: no signal set twice in one step
    endtask : xfer
    // Command word, then poll until the flag, at most 40 reads; result taken from the last read
    task automatic run_cmd(input logic [15:0] code, input logic [15:0] arg,
                           output logic [7:0] st);
        logic [31:0] r;
        logic        e;
        int          n;
        xfer(1'b1, ADDR_CMD, {arg, code}, r, e);
        n = 0;
        r = 32'h0;
        while (r[8] !== 1'b1 && n < 40) begin
            xfer(1'b0, ADDR_STATUS, 32'h0, r, e);
            n++;
        end
        st = r[7:0];
    endtask : run_cmd
endmodule : fwce_host_model

/* tb/fwce_engine_test.sv */
// Testbench: drives the engine through the host model, checks replies.
// Assumes package, engine, host model and checker are compiled first.
`timescale 1ns/1ps
module fwce_engine_test
    import fwce_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        update_supported, factory_present, image_check_ok, e;
    logic [1:0]  running_bank;
    logic        command_done;
    logic [7:0]  st;
    int          errors, tests_run;
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    fwce_engine fwce_engine_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .update_supported(update_supported),
        .factory_present(factory_present), .image_check_ok(image_check_ok),
        .running_bank(running_bank), .command_done(command_done));
    fwce_host_model fwce_host_model_inst (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [15:0] c, input logic [15:0] a,
                       input logic [7:0] exp);
        fwce_host_model_inst.run_cmd(c, a, st);
        chk({24'h0, st}, {24'h0, exp});
        chk({31'h0, command_done}, 32'h1);
    endtask : cmd
    // Refused command: anything but success
    task automatic nok(input logic [15:0] c, input logic [15:0] a);
        fwce_host_model_inst.run_cmd(c, a, st);
        chk({31'h0, st == ST_SUCCESS}, 32'h0);
    endtask : nok
    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        fwce_host_model_inst.xfer(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask : rd
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Watchdog well beyond the roughly 400 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        tests_run = 0;
        presetn = 1'b0;
        update_supported = 1'b1;
        factory_present = 1'b1;
        image_check_ok = 1'b1;
        do_reset();
        rd(ADDR_FWSTAT, 32'hFF, 32'h03);
        chk({30'h0, running_bank}, {30'h0, BANK_A});
        rd(ADDR_HDR_LEN, 32'hFF, {24'h0, HDR_LEN_RESET});
        rd(ADDR_CAPS, 32'h3, 32'h3);
        rd(12'h018, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, e}, 32'h1);
        cmd(CMD_FEATURES, 16'h0, ST_SUCCESS);
        cmd(CMD_INFO, 16'h0, ST_SUCCESS);
        cmd(CMD_WR_LOCAL, 16'h0, ST_NO_SESS);
        cmd(CMD_COMPLETE, 16'h0, ST_NO_SESS);
        cmd(CMD_START, 16'h1, ST_SUCCESS);
        rd(ADDR_FWSTAT, 32'hFF, 32'h43);
        nok(CMD_RUN, 16'h1);
        nok(CMD_COMMIT, 16'h1);
        cmd(CMD_WR_LOCAL, 16'h0, ST_SUCCESS);
        cmd(CMD_WR_EXT, 16'h0, ST_SUCCESS);
        rd(ADDR_BLK_ADDR, 32'hFFFF, 32'h2);
        rd(ADDR_FWSTAT, 32'hFF, 32'h43);
        cmd(CMD_COMPLETE, 16'h0, ST_SUCCESS);
        rd(ADDR_FWSTAT, 32'hFF, 32'h03);
        image_check_ok <= 1'b0;
        cmd(CMD_START, 16'h1, ST_SUCCESS);
        cmd(CMD_WR_LOCAL, 16'h0, ST_SUCCESS);
        cmd(CMD_COMPLETE, 16'h0, ST_VAL_FAIL);
        rd(ADDR_FWSTAT, 32'hFF, 32'h43);
        cmd(CMD_COMPLETE, 16'h0, ST_NO_SESS);
        nok(CMD_RUN, 16'h1);
        image_check_ok <= 1'b1;
        cmd(CMD_START, 16'h1, ST_SUCCESS);
        cmd(CMD_ABORT, 16'h0, ST_SUCCESS);
        cmd(CMD_WR_EXT, 16'h0, ST_NO_SESS);
        rd(ADDR_FWSTAT, 32'hFF, 32'h43);
        cmd(CMD_START, 16'h1, ST_SUCCESS);
        cmd(CMD_WR_EXT, 16'h0, ST_SUCCESS);
        cmd(CMD_COMPLETE, 16'h0, ST_SUCCESS);
        cmd(CMD_RUN, 16'h1, ST_SUCCESS);
        rd(ADDR_FWSTAT, 32'hFF, 32'h12);
        chk({30'h0, running_bank}, {30'h0, BANK_B});
        do_reset();
        rd(ADDR_FWSTAT, 32'hFF, 32'h03);
        chk({30'h0, running_bank}, {30'h0, BANK_A});
        cmd(CMD_RUN, 16'h1, ST_SUCCESS);
        cmd(CMD_COMMIT, 16'h1, ST_SUCCESS);
        rd(ADDR_FWSTAT, 32'hFF, 32'h30);
        cmd(CMD_COPY, 16'h0, ST_SUCCESS);
        rd(ADDR_FWSTAT, 32'h22, 32'h20);
        update_supported <= 1'b0;
        cmd(CMD_START, 16'h1, ST_BAD_CMD);
        rd(ADDR_CAPS, 32'h1, 32'h0);
        cmd(CMD_INFO, 16'h0, ST_SUCCESS);
        update_supported <= 1'b1;
        fwce_host_model_inst.xfer(1'b1, ADDR_STATUS, 32'h100, r, e);
        rd(ADDR_STATUS, 32'h100, 32'h0);
        chk({31'h0, command_done}, 32'h0);
        print_verdict();
    end
endmodule : fwce_engine_test
bind fwce_engine fwce_engine_asserts fwce_engine_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .update_supported(update_supported),
    .factory_present(factory_present), .image_check_ok(image_check_ok),
    .running_bank(running_bank), .command_done(command_done));
